//--- link_ctrl.v
// Physical-layer link control: directed width and speed change, capability
// status, low-power state reporting and transceiver controls.
// Assumes transceiver and training inputs are synchronous to clk.
//
// Design decisions made here: the register addresses and register access over Wishbone.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module link_ctrl (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [3:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire [1:0] directed_change_request,
  input wire [1:0] directed_target_width,
  input wire directed_target_speed,
  input wire [5:0] directed_new_state_bus,
  input wire directed_new_state_valid,
  input wire directed_state_stall,
  input wire directed_change_autonomous,
  output reg directed_change_complete,
  input wire upstream_preferred_deemphasis,
  input wire downstream_deemphasis_source,
  input wire phy_status,
  input wire rx_receiver_present,
  input wire link_trained,
  input wire [1:0] trained_width,
  input wire partner_upcfg_bit,
  input wire partner_rate5_advert,
  input wire partner_deemph_pref,
  input wire link_lost,
  input wire tx_idle,
  input wire rx_elec_idle,
  input wire rx_fts_seen,
  output wire [2:0] tx_low_power_state,
  output wire [1:0] rx_low_power_state,
  output reg upconfigure_capable,
  output reg higher_rate_capable,
  output reg partner_higher_rate_support,
  output reg [2:0] initial_negotiated_width,
  output reg tx_receiver_detect,
  output reg tx_pcs_reset,
  output reg tx_signalling_rate,
  output reg tx_deemphasis_select,
  output reg [2:0] tx_voltage_margin,
  output reg current_link_rate
);
  ////////////////////////////////////////////////////////////////////////////
  // States of the training walk, one-hot.
  localparam [4:0] ST_DET = 5'h01;
  localparam [4:0] ST_CFG = 5'h02;
  localparam [4:0] ST_L0 = 5'h04;
  localparam [4:0] ST_RCV = 5'h08;
  localparam [4:0] ST_HOLD = 5'h10;

  reg [4:0] state_r; // Current training state.
  reg [7:0] cnt_r; // Shared dwell counter.
  reg [1:0] width_r; // Current width code, x1 to x8.
  reg trained_once_r; // Set after the first training completes.
  reg upcfg_seen_r; // Partner upconfigure bit caught in configuration.
  reg pend_width_r; // Width change under way.
  reg pend_speed_r; // Speed change under way.
  reg spd_wait_r; // Waiting for the transceiver after a rate switch.
  reg auton_r; // Mode of the last accepted change.
  reg [1:0] req_seen_r; // Last accepted request code.
  reg [7:0] ctrl_r; // Control register.
  reg tie_bad_r; // Sticky flag: an unsupported input was not held at zero.
  reg ack_r; // Bus acknowledge.

  // Width code to the initial-width encoding, x1 as 001 up to x8 as 100.
  function [2:0] enc_width;
    input [1:0] w;
    begin
      enc_width = {1'b0, w} + 3'h1;
    end
  endfunction

  // A rate is reachable when it is 2.5 or both ends support 5.0.
  function rate_ok;
    input target;
    input cap;
    begin
      rate_ok = (target == `RATE_2P5) || cap;
    end
  endfunction

  wire [2:0] tx_lp_state; // From the transmit sequencer.
  wire [1:0] rx_lp_state; // From the receive tracker.
  wire in_l0 = (state_r == ST_L0);
  wire l0s_allow = in_l0 && ctrl_r[`CTRL_L0S_EN];
  wire rate5_sup = ctrl_r[`CTRL_RATE5_SUP];
  // Width and speed fields are looked at only under their request bit.
  wire want_width = directed_change_request[0]
    && (directed_target_width != width_r)
    && ((enc_width(directed_target_width) <= initial_negotiated_width)
    || upconfigure_capable);
  wire want_speed = directed_change_request[1]
    && (directed_target_speed != tx_signalling_rate)
    && rate_ok(directed_target_speed, higher_rate_capable);

  ////////////////////////////////////////////////////////////////////////////
  // Training walk and directed change engine.
  always @(posedge clk) begin
    if (srst) begin
      state_r <= ST_DET;
      cnt_r <= 8'h00;
      width_r <= 2'h0;
      trained_once_r <= 1'b0;
      upcfg_seen_r <= 1'b0;
      pend_width_r <= 1'b0;
      pend_speed_r <= 1'b0;
      spd_wait_r <= 1'b0;
      auton_r <= 1'b0;
      req_seen_r <= 2'h0;
      directed_change_complete <= 1'b0;
      upconfigure_capable <= 1'b0;
      higher_rate_capable <= 1'b0;
      partner_higher_rate_support <= 1'b0;
      initial_negotiated_width <= `WIDTH_UNTRAINED;
      tx_receiver_detect <= 1'b0;
      tx_pcs_reset <= 1'b1;
      tx_signalling_rate <= `RATE_2P5;
      current_link_rate <= `RATE_2P5;
    end else if (link_lost && !state_r[0]) begin
      // Losing the link drops back to detect at the base rate.
      state_r <= ST_DET;
      cnt_r <= 8'h00;
      pend_width_r <= 1'b0;
      pend_speed_r <= 1'b0;
      spd_wait_r <= 1'b0;
      directed_change_complete <= 1'b0;
      tx_pcs_reset <= 1'b1;
      tx_signalling_rate <= `RATE_2P5;
      current_link_rate <= `RATE_2P5;
    end else begin
      case (state_r)
        ST_DET: begin
          cnt_r <= cnt_r + 8'h01;
          if (tx_pcs_reset) begin
            // Hold the coding sublayer in reset for its least time.
            if (cnt_r == `PCS_RESET_CYC - 1) begin
              tx_pcs_reset <= 1'b0;
              tx_receiver_detect <= 1'b1;
              cnt_r <= 8'h00;
            end
          end else if (tx_receiver_detect) begin
            // The transceiver sits in P1 here; its status pulse ends detection.
            if (phy_status) begin
              tx_receiver_detect <= 1'b0;
              cnt_r <= 8'h00;
              if (rx_receiver_present) begin
                state_r <= ST_CFG;
                upcfg_seen_r <= 1'b0;
              end
            end
          end else if (cnt_r == `DET_RETRY_CYC - 1) begin
            // Nobody answered: retry after a pause, never continuously.
            tx_receiver_detect <= 1'b1;
          end
        end
        ST_CFG: begin
          if (partner_upcfg_bit) begin
            upcfg_seen_r <= 1'b1;
          end
          if (link_trained) begin
            width_r <= trained_width;
            if (!trained_once_r) begin
              trained_once_r <= 1'b1;
              initial_negotiated_width <= enc_width(trained_width);
            end
            upconfigure_capable <= (upcfg_seen_r || partner_upcfg_bit)
              && ctrl_r[`CTRL_UPCFG_SUP];
            partner_higher_rate_support <= partner_rate5_advert;
            higher_rate_capable <= partner_rate5_advert && rate5_sup;
            state_r <= ST_L0;
          end
        end
        ST_L0: begin
          cnt_r <= 8'h00;
          if (directed_change_request == 2'h0) begin
            // The request is a level: completion stays until it is removed.
            directed_change_complete <= 1'b0;
          end else if (!directed_change_complete) begin
            req_seen_r <= directed_change_request;
            auton_r <= directed_change_autonomous;
            if (want_width || want_speed) begin
              pend_width_r <= want_width;
              pend_speed_r <= want_speed;
              state_r <= ST_RCV;
            end else begin
              // Already at the target, or the target is not reachable: nothing to train, report done.
              directed_change_complete <= 1'b1;
            end
          end
        end
        ST_RCV: begin
          cnt_r <= cnt_r + 8'h01;
          if (pend_width_r) begin
            width_r <= directed_target_width;
            pend_width_r <= 1'b0;
          end
          if (pend_speed_r) begin
            if (cnt_r == `RATE_SWITCH_CYC - 1) begin
              tx_signalling_rate <= directed_target_speed;
              current_link_rate <= directed_target_speed;
              pend_speed_r <= 1'b0;
              spd_wait_r <= 1'b1;
            end
          end else if (!spd_wait_r || phy_status) begin
            spd_wait_r <= 1'b0;
            state_r <= ST_HOLD;
          end
        end
        ST_HOLD: begin
          // Back to L0: refresh partner rate flags and report completion in the same cycle.
          partner_higher_rate_support <= partner_rate5_advert;
          higher_rate_capable <= partner_rate5_advert && rate5_sup;
          directed_change_complete <= 1'b1;
          state_r <= ST_L0;
        end
        default: begin
          state_r <= ST_DET;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // De-emphasis policy, re-evaluated every cycle from its sources.
  always @(posedge clk) begin
    if (srst) begin
      tx_deemphasis_select <= `DEEMPH_3P5DB;
    end else if (ctrl_r[`CTRL_UPSTREAM]) begin
      tx_deemphasis_select <= upstream_preferred_deemphasis;
    end else if (tx_signalling_rate == `RATE_5P0) begin
      tx_deemphasis_select <= downstream_deemphasis_source ?
        ctrl_r[`CTRL_SEL_DEEMPH] : partner_deemph_pref;
    end else begin
      // At 2.5 the lighter setting is fixed.
      tx_deemphasis_select <= `DEEMPH_3P5DB;
    end
  end

  // Margin follows the control field; reset leaves the normal range.
  always @(posedge clk) begin
    if (srst) begin
      tx_voltage_margin <= 3'h0;
    end else begin
      tx_voltage_margin <= ctrl_r[`CTRL_MARGIN_HI:`CTRL_MARGIN_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Low-power state reporting.
  tx_l0s_seq u_tx_lp (
    .clk(clk),
    .srst(srst),
    .allow(l0s_allow),
    .tx_idle(tx_idle),
    .state_r(tx_lp_state)
  );

  rx_l0s_seq u_rx_lp (
    .clk(clk),
    .srst(srst),
    .allow(l0s_allow),
    .rx_elec_idle(rx_elec_idle),
    .rx_fts_seen(rx_fts_seen),
    .state_r(rx_lp_state)
  );

  assign tx_low_power_state = tx_lp_state;
  assign rx_low_power_state = rx_lp_state;

  ////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: one wait state, ack high for exactly one cycle.
  wire wb_req = wb_cyc_i && wb_stb_i && !ack_r;
  wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
  wire tie_hit = (directed_new_state_bus != 6'h00)
    || directed_new_state_valid || directed_state_stall;
  wire tie_clr = wb_wr && (wb_adr_i == `ADR_DIRECTED)
    && wb_dat_i[`DIR_TIE_BIT];

  assign wb_ack_o = ack_r;

  // Register writes; only the low byte lane carries writable bits.
  always @(posedge clk) begin
    if (srst) begin
      ack_r <= 1'b0;
      ctrl_r <= `CTRL_RESET;
      tie_bad_r <= 1'b0;
    end else begin
      ack_r <= wb_req;
      if (wb_wr && (wb_adr_i == `ADR_CTRL)) begin
        ctrl_r <= wb_dat_i[7:0];
      end
      // A new violation in the clearing cycle keeps the flag set.
      if (tie_hit) begin
        tie_bad_r <= 1'b1;
      end else if (tie_clr) begin
        tie_bad_r <= 1'b0;
      end
    end
  end

  // Read data, registered; unmapped addresses answer zero.
  always @(posedge clk) begin
    if (srst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (wb_req) begin
      case (wb_adr_i)
        `ADR_CTRL: begin
          wb_dat_o <= {24'h00_0000, ctrl_r};
        end
        `ADR_STATUS: begin
          wb_dat_o <= {11'h000, state_r, tx_lp_state, rx_lp_state,
            initial_negotiated_width, width_r, current_link_rate,
            partner_higher_rate_support, higher_rate_capable,
            upconfigure_capable, directed_change_complete, trained_once_r};
        end
        `ADR_DIRECTED: begin
          wb_dat_o <= {24'h00_0000, tie_bad_r, auton_r, req_seen_r,
            pend_width_r, pend_speed_r, spd_wait_r, upcfg_seen_r};
        end
        default: begin
          wb_dat_o <= 32'h0000_0000;
        end
      endcase
    end
  end
endmodule

//--- link_ctrl_checker.sv
// Port-level properties of the link control block.
// Assumes it is bound into link_ctrl and sees only that module's ports.
`timescale 1ns/1ps
module link_ctrl_checker (
  input wire clk,
  input wire srst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire [1:0] directed_change_request,
  input wire directed_change_complete,
  input wire [2:0] tx_low_power_state,
  input wire higher_rate_capable,
  input wire partner_higher_rate_support,
  input wire [2:0] initial_negotiated_width,
  input wire tx_receiver_detect,
  input wire tx_pcs_reset,
  input wire tx_signalling_rate,
  input wire current_link_rate
);
  // One clock domain, so one clocking and one disable serve every property.
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (srst);

  ////////////////////////////////////////////////////////////////////////////
  // Bus handshake: the answer comes exactly one cycle after a request is taken.
  a_ack_one_late: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("ack not one cycle after request");
  a_ack_one_wide: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack wider than one cycle");

  ////////////////////////////////////////////////////////////////////////////
  // Directed change: completion only with a request, and it clears after 00.
  a_done_needs_req: assert property ($rose(directed_change_complete) |->
    directed_change_request != 2'h0) else $error("completion without request");
  a_done_clears: assert property (directed_change_complete &&
    directed_change_request == 2'h0 |-> ##[1:3] !directed_change_complete)
    else $error("completion did not clear");
  a_speed_needs_req: assert property ($rose(tx_signalling_rate) |->
    directed_change_request[1]) else $error("rate rose without speed request");

  ////////////////////////////////////////////////////////////////////////////
  // Line and status codes.
  a_rate_twin: assert property (tx_signalling_rate == current_link_rate)
    else $error("rate outputs disagree");
  a_tx_code_legal: assert property (tx_low_power_state[2] == 1'b0)
    else $error("reserved transmit power code");
  a_width_legal: assert property (initial_negotiated_width <= 3'h4)
    else $error("initial width code out of range");
  a_width_sticky: assert property (initial_negotiated_width != 3'h0 |=>
    $stable(initial_negotiated_width)) else $error("initial width changed");
  a_cap_partner: assert property (higher_rate_capable |->
    partner_higher_rate_support) else $error("capable without partner support");
  a_detect_clean: assert property (tx_receiver_detect |-> !tx_pcs_reset)
    else $error("receiver detect during coding sublayer reset");

  // Main scenarios reached.
  c_done: cover property ($rose(directed_change_complete));
  c_rate_up: cover property ($rose(tx_signalling_rate));
  c_tx_idle: cover property (tx_low_power_state == 3'h2);
endmodule

bind link_ctrl link_ctrl_checker u_chk (.clk(clk), .srst(srst), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o), .directed_change_request(directed_change_request),
  .directed_change_complete(directed_change_complete), .tx_low_power_state(tx_low_power_state),
  .higher_rate_capable(higher_rate_capable),
  .partner_higher_rate_support(partner_higher_rate_support),
  .initial_negotiated_width(initial_negotiated_width),
  .tx_receiver_detect(tx_receiver_detect), .tx_pcs_reset(tx_pcs_reset),
  .tx_signalling_rate(tx_signalling_rate), .current_link_rate(current_link_rate));

//--- link_ctrl_map.vh
// Constants of the physical-layer link control block: bus map, fields, codes, timing.
// Assumes a single 200 MHz clock and a classic Wishbone master with 32-bit data.
`ifndef LINK_CTRL_MAP_VH
`define LINK_CTRL_MAP_VH
// Register byte addresses.
`define ADR_CTRL 4'h0
`define ADR_STATUS 4'h4
`define ADR_DIRECTED 4'h8
// Control register fields and reset value.
`define CTRL_RESET 8'h00
`define CTRL_UPCFG_SUP 0
`define CTRL_RATE5_SUP 1
`define CTRL_UPSTREAM 2
`define CTRL_SEL_DEEMPH 3
`define CTRL_L0S_EN 4
`define CTRL_MARGIN_LO 5
`define CTRL_MARGIN_HI 7
// Directed register: bit written with one clears the tie-off flag.
`define DIR_TIE_BIT 7
// Line codes.
`define RATE_2P5 1'b0
`define RATE_5P0 1'b1
`define DEEMPH_6DB 1'b0
`define DEEMPH_3P5DB 1'b1
`define WIDTH_UNTRAINED 3'h0
`define TX_NOT_L0S 3'h0
`define TX_L0S_ENTRY 3'h1
`define TX_L0S_IDLE 3'h2
`define TX_L0S_FTS 3'h3
`define RX_NOT_L0S 2'h0
`define RX_L0S_ENTRY 2'h1
`define RX_L0S_IDLE 2'h2
`define RX_L0S_FTS 2'h3
// Timing in ns and the derived cycle counts (least times round up).
`define CLK_NS 5
`define PCS_RESET_NS 100
`define PCS_RESET_CYC ((`PCS_RESET_NS + `CLK_NS - 1) / `CLK_NS)
`define DET_RETRY_NS 1000
`define DET_RETRY_CYC ((`DET_RETRY_NS + `CLK_NS - 1) / `CLK_NS)
`define RATE_SWITCH_NS 800
`define RATE_SWITCH_CYC ((`RATE_SWITCH_NS + `CLK_NS - 1) / `CLK_NS)
`define L0S_ENTRY_NS 40
`define L0S_ENTRY_CYC ((`L0S_ENTRY_NS + `CLK_NS - 1) / `CLK_NS)
`define L0S_FTS_NS 160
`define L0S_FTS_CYC ((`L0S_FTS_NS + `CLK_NS - 1) / `CLK_NS)
`endif

//--- link_ctrl_tb.sv
// Self-checking bench for the link control block.
// Assumes the phy model stands in for the transceiver and the training partner.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module link_ctrl_tb;
  logic clk, srst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [3:0] wb_adr_i, wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o, junk;
  logic [1:0] directed_change_request, directed_target_width, trained_width;
  logic directed_target_speed, directed_change_autonomous, directed_change_complete;
  logic [5:0] directed_new_state_bus;
  logic directed_new_state_valid, directed_state_stall, link_lost;
  logic upstream_preferred_deemphasis, downstream_deemphasis_source;
  logic phy_status, rx_receiver_present, link_trained, partner_deemph_pref;
  logic partner_upcfg_bit, partner_rate5_advert, tx_idle, rx_elec_idle, rx_fts_seen;
  logic [2:0] tx_low_power_state, initial_negotiated_width, tx_voltage_margin;
  logic [1:0] rx_low_power_state;
  logic upconfigure_capable, higher_rate_capable, partner_higher_rate_support;
  logic tx_receiver_detect, tx_pcs_reset, tx_signalling_rate, tx_deemphasis_select;
  logic current_link_rate;
  int miscompares, checked;

  link_ctrl u_dut (.*);
  phy_model u_phy (.*);

  ////////////////////////////////////////////////////////////////////////////
  // Compare a port value.
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Classic single cycle; ack and read data are taken at the rising edge that samples ack.
  // The request stands untouched until then, for up to 19 wait states of the slave.
  task automatic wb_xfer(input logic w, input logic [3:0] a, input logic [3:0] s,
                         input logic [31:0] d, output logic [31:0] q);
    int n = 0;
    @(posedge clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    chk("bus ack", 1, wb_ack_o);
    q = wb_dat_o;
    // Release right after the edge that sampled ack; the next call waits one more edge.
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask

  // Compare the masked word of a register read.
  task automatic chk_reg(input string what, input logic [3:0] a, input logic [31:0] m,
                         input logic [31:0] e);
    logic [31:0] q;
    wb_xfer(1'b0, a, 4'hf, 32'h0, q);
    chk(what, e, q & m);
  endtask

  // Wait, bounded, for the completion flag to reach a level.
  task automatic wait_done(input logic lvl, input int lim);
    int n = 0;
    while (directed_change_complete !== lvl && n < lim) begin
      @(negedge clk);
      n++;
    end
    chk("complete", lvl, directed_change_complete);
  endtask

  // One directed change, then the request returns to none.
  task automatic direct(input logic [1:0] r, input logic [1:0] w, input logic s,
                        input logic au);
    @(posedge clk);
    directed_target_width <= w;
    directed_target_speed <= s;
    directed_change_autonomous <= au;
    directed_change_request <= r;
    wait_done(1'b1, 3000);
    @(posedge clk);
    directed_change_request <= 2'h0;
    wait_done(1'b0, 20);
  endtask

  task automatic close_out();
    if (miscompares == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Cuts a hang short; the tests need a few hundred cycles.
  initial begin
    repeat (20000) @(posedge clk);
    miscompares++;
    close_out();
  end

  initial begin
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i, directed_change_request,
     directed_target_width, directed_target_speed, directed_new_state_bus,
     directed_new_state_valid, directed_state_stall, directed_change_autonomous,
     upstream_preferred_deemphasis, partner_deemph_pref, link_lost, tx_idle,
     rx_elec_idle, rx_fts_seen} = '0;
    {partner_upcfg_bit, partner_rate5_advert, downstream_deemphasis_source} = 3'h7;
    trained_width = 2'h2;
    srst = 1'b1;
    miscompares = 0;
    checked = 0;
    repeat (12) @(posedge clk);
    @(negedge clk);
    chk("pcs reset", 1, tx_pcs_reset);
    chk("rate", 0, tx_signalling_rate);
    chk("deemph", 1, tx_deemphasis_select);
    chk("margin", 0, tx_voltage_margin);
    chk("init width", 0, initial_negotiated_width);
    @(posedge clk);
    srst <= 1'b0;
    // Registers: reset value, unmapped place, byte-lane refusal.
    chk_reg("ctrl", `ADR_CTRL, 32'hff, {24'h0, `CTRL_RESET});
    chk_reg("unmapped", 4'hc, 32'hffffffff, 32'h0);
    wb_xfer(1'b1, `ADR_CTRL, 4'hf, 32'ha3, junk);
    wb_xfer(1'b1, `ADR_CTRL, 4'he, 32'h0, junk);
    chk_reg("ctrl", `ADR_CTRL, 32'hff, 32'ha3);
    chk("margin", 3'h5, tx_voltage_margin);
    // Training: x4 negotiated, partner offers both abilities.
    for (int n = 0; n < 2000 && initial_negotiated_width === 3'h0; n++) @(negedge clk);
    chk("init width", 3'h3, initial_negotiated_width);
    chk("upcfg cap", 1, upconfigure_capable);
    chk("rate cap", 1, higher_rate_capable);
    chk("partner sup", 1, partner_higher_rate_support);
    chk_reg("status", `ADR_STATUS, 32'h721, 32'h301);
    // Width only; the speed field must be ignored.
    direct(2'h1, 2'h0, 1'b1, 1'b1);
    chk("rate", 0, tx_signalling_rate);
    chk_reg("directed", `ADR_DIRECTED, 32'hf0, 32'h50);
    // Speed only, to the higher rate.
    direct(2'h2, 2'h3, 1'b1, 1'b0);
    chk("rate", 1, tx_signalling_rate);
    chk("link rate", 1, current_link_rate);
    chk("deemph", 0, tx_deemphasis_select);
    chk_reg("width", `ADR_STATUS, 32'hc0, 32'h0);
    @(posedge clk);
    downstream_deemphasis_source <= 1'b0;
    partner_deemph_pref <= 1'b1;
    repeat (4) @(negedge clk);
    chk("deemph", 1, tx_deemphasis_select);
    // Both at once, back to the lower rate.
    direct(2'h3, 2'h1, 1'b0, 1'b0);
    chk("rate", 0, tx_signalling_rate);
    chk("link rate", 0, current_link_rate);
    // Low-power states once enabled; setting_a takes the supplied preference.
    wb_xfer(1'b1, `ADR_CTRL, 4'h1, 32'hb7, junk);
    tx_idle <= 1'b1;
    rx_elec_idle <= 1'b1;
    repeat (40) @(negedge clk);
    chk("tx state", `TX_L0S_IDLE, tx_low_power_state);
    chk("rx state", `RX_L0S_IDLE, rx_low_power_state);
    chk("deemph", 0, tx_deemphasis_select);
    close_out();
  end
endmodule

//--- phy_model.sv
// Behavioural transceiver: answers receiver detection and rate switches.
// Assumes detect is held until the status pulse, as the block does.
`timescale 1ns/1ps
module phy_model #(
  parameter int DET_DLY = 10,
  parameter int RATE_DLY = 20,
  parameter int TRAIN_DLY = 8
) (
  input wire clk,
  input wire srst,
  input wire tx_pcs_reset,
  input wire tx_receiver_detect,
  input wire tx_signalling_rate,
  output logic phy_status,
  output logic rx_receiver_present,
  output logic link_trained
);
  int cnt; // Cycles to the next status pulse; zero means idle.
  int trn; // Cycles to the training pulse.
  logic det_q; // Detect seen last cycle.
  logic rate_q; // Rate seen last cycle.

  // A receiver is always attached in this bench.
  assign rx_receiver_present = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Status is a one-cycle pulse; a coding sublayer in reset answers nothing.
  always @(posedge clk) begin
    det_q <= tx_receiver_detect;
    rate_q <= tx_signalling_rate;
    phy_status <= 1'b0;
    link_trained <= 1'b0;
    if (srst || tx_pcs_reset) begin
      cnt <= 0;
      trn <= 0;
    end else begin
      if (tx_receiver_detect && !det_q) begin
        cnt <= DET_DLY;
      end else if (tx_signalling_rate != rate_q) begin
        cnt <= RATE_DLY;
      end else if (cnt == 1) begin
        phy_status <= 1'b1;
        cnt <= 0;
        // Training follows a successful detection only.
        if (tx_receiver_detect) begin
          trn <= TRAIN_DLY;
        end
      end else if (cnt > 1) begin
        cnt <= cnt - 1;
      end
      if (trn == 1) begin
        link_trained <= 1'b1;
      end
      if (trn > 0) begin
        trn <= trn - 1;
      end
    end
  end
endmodule

//--- rx_l0s_seq.v
// Receive low-power tracker driven by electrical idle and fast training detection.
// Assumes rx_elec_idle and rx_fts_seen are synchronous levels from the transceiver.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module rx_l0s_seq (
  input wire clk,
  input wire srst,
  input wire allow,
  input wire rx_elec_idle,
  input wire rx_fts_seen,
  output reg [1:0] state_r
);
  // The tracker leaves L0s once fast training is seen or allow drops, never on a timeout.
  always @(posedge clk) begin
    if (srst || !allow) begin
      state_r <= `RX_NOT_L0S;
    end else begin
      case (state_r)
        `RX_NOT_L0S: begin
          if (rx_elec_idle) begin
            state_r <= `RX_L0S_ENTRY;
          end
        end
        `RX_L0S_ENTRY: begin
          state_r <= rx_elec_idle ? `RX_L0S_IDLE : `RX_L0S_FTS;
        end
        `RX_L0S_IDLE: begin
          if (!rx_elec_idle) begin
            state_r <= `RX_L0S_FTS;
          end
        end
        default: begin
          if (rx_fts_seen) begin
            state_r <= `RX_NOT_L0S;
          end
        end
      endcase
    end
  end
endmodule

//--- tx_l0s_seq.v
// Transmit low-power sequencer: walks not-in-L0s, entry, idle, fast training.
// Assumes the caller gates allow low whenever the link is not in L0.
`timescale 1ns/1ps
`include "link_ctrl_map.vh"
module tx_l0s_seq (
  input wire clk,
  input wire srst,
  input wire allow,
  input wire tx_idle,
  output reg [2:0] state_r
);
  reg [7:0] cnt_r; // Dwell counter for entry and fast training phases.

  // Only the four defined codes are ever loaded, so reserved codes never show.
  always @(posedge clk) begin
    if (srst || !allow) begin
      state_r <= `TX_NOT_L0S;
      cnt_r <= 8'h00;
    end else begin
      cnt_r <= cnt_r + 8'h01;
      case (state_r)
        `TX_NOT_L0S: begin
          cnt_r <= 8'h00;
          if (tx_idle) begin
            state_r <= `TX_L0S_ENTRY;
          end
        end
        `TX_L0S_ENTRY: begin
          if (cnt_r == `L0S_ENTRY_CYC - 1) begin
            state_r <= `TX_L0S_IDLE;
          end
        end
        `TX_L0S_IDLE: begin
          cnt_r <= 8'h00;
          if (!tx_idle) begin
            state_r <= `TX_L0S_FTS;
          end
        end
        default: begin
          // Fast training sequences run a fixed time before normal traffic.
          if (cnt_r == `L0S_FTS_CYC - 1) begin
            state_r <= `TX_NOT_L0S;
          end
        end
      endcase
    end
  end
endmodule
